// >>> pe_model.sv
`timescale 1ns/1ps
`default_nettype none
module pe_model
  import virq_if_pkg::*;
(
  input  wire logic      clk_i,               // Clock
  input  wire logic      irq_i,               // Interrupt from interface
  output var bus_req_type vreq_o              // Guest register access
);
  // ****
  // Guest register access
  // ****
  initial vreq_o = '0;
  // One access held through its taking edge
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1 vreq_o = {1'b1, w, a, d};
    @(posedge clk_i);
    // Released lines show the inverse, not stale values
    #1 vreq_o = {1'b0, ~w, ~a, ~d};
  endtask : access
endmodule : pe_model
`default_nettype wire

// >>> test_virq_cpu_if.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_virq_cpu_if
  import virq_if_pkg::*;
;
  // ****
  // Bench signals
  // ****
  localparam int          PB    = 5;                          // Priority bits
  localparam logic [7:0]  MK    = 8'hff << (8 - PB);          // Kept mask bits
  localparam logic [31:0] IDENT = {12'h123, 4'h3, 4'h2, 4'h5, 1'b0, 7'h11}; // Arbitrary ids
  logic        clk, rstn, sysreg, pend_v, ack, eoi, irq, ri;  // Scalar pins
  logic        expi[$];                                       // Expected interrupt levels
  logic [7:0]  pend_p, ack_p, p;                              // Priorities
  bus_req_type vreq, hreq;                                    // Requests
  bus_rsp_type vrsp, hrsp;                                    // Answers
  logic [31:0] expv[$], exph[$], rv, r;                       // Expected reads
  int          n_errors, tests_run, cycles, seed;             // Counters
  logic [11:0] fa[4] = '{12'h008, 12'h008, 12'h010, 12'h00c}; // Violation address
  logic        fw[4] = '{1'b0, 1'b1, 1'b0, 1'b1};             // Violation write
  virq_cpu_if #(.PRIO_BITS(PB), .PRODUCT(12'h123), .ARCH_VER(4'h3), .REVISION(4'h2),
    .IMPL_CONT(4'h5), .IMPL_CODE(7'h11)) uut (.clk_i(clk), .rstn_i(rstn), .vreq_i(vreq),
    .vrsp_o(vrsp), .hreq_i(hreq), .hrsp_o(hrsp), .sysreg_en_i(sysreg), .pend_valid_i(pend_v),
    .pend_prio_i(pend_p), .ack_i(ack), .ack_prio_i(ack_p), .eoi_i(eoi), .irq_o(irq));
  pe_model pe (.clk_i(clk), .irq_i(irq), .vreq_o(vreq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****
  // Drivers
  // ****
  // hypervisor-only control access
  task automatic hacc(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    if (!w) exph.push_back(e);
    @(posedge clk);
    #1 hreq = {1'b1, w, a, d};
    @(posedge clk);
    #1 hreq = {1'b0, ~w, ~a, ~d};
  endtask : hacc
  task automatic vacc(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    if (!w) expv.push_back(e);
    pe.access(w, a, d);
  endtask : vacc
  task automatic pulse(input logic is_ack, input logic [7:0] pr);
    @(posedge clk);
    #1 {ack, ack_p, eoi} = {is_ack, pr, !is_ack};
    @(posedge clk);
    #1 {ack, eoi} = 2'b00;
  endtask : pulse
  task automatic irq_chk(input logic [7:0] pr, input logic ex);
    @(posedge clk);
    #1 {pend_v, pend_p} = {1'b1, pr};
    @(posedge clk);
    #1 expi.push_back(ex);
  endtask : irq_chk
  task automatic give_verdict();
    // Answers still owed count as a mismatch
    if (expv.size() + exph.size() + expi.size() > 0) n_errors++;
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // ****
  // Answer watcher and timeout
  // ****
  always @(negedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      n_errors++;
      give_verdict();
    end
    if (vrsp.valid === 1'b1) begin
      rv = expv.pop_front();
      `CHK("vbank", rv, vrsp.rdata)
    end
    if (hrsp.valid === 1'b1) begin
      rv = exph.pop_front();
      `CHK("hbank", rv, hrsp.rdata)
    end
    if (expi.size() > 0) begin
      ri = expi.pop_front();
      `CHK("irq", ri, irq)
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 99851;
    {rstn, sysreg, pend_v, pend_p, ack, ack_p, eoi} = '0;
    hreq = '0;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    vacc(0, VOFF_IDENT, 0, IDENT);
    vacc(0, VOFF_RUNPRI, 0, {24'h0, IDLE_PRI_5BIT});
    hacc(0, HOFF_EMPTY, 0, 32'h0000ffff);
    hacc(0, HOFF_APR_LO, 0, 32'h0);
    p = 8'($random(seed));
    vacc(1, VOFF_MASK, {24'h0, p}, 0);
    vacc(0, VOFF_MASK, 0, {24'h0, p & MK});
    hacc(0, HOFF_VMCR, 0, {p & MK, 24'h0});
    hacc(1, HOFF_VMCR, 32'h80abcdef, 0);
    hacc(0, HOFF_VMCR, 0, 32'h80abcdef);
    vacc(0, VOFF_MASK, 0, 32'h80);
    irq_chk(8'h10, 1'b0);
    hacc(1, HOFF_CTRL, 32'h1, 0);
    hacc(0, HOFF_CTRL, 0, 32'h1);
    hacc(1, HOFF_TYPE, 32'h0, 0);
    hacc(0, HOFF_TYPE, 0, 32'h8000_0000);
    irq_chk(8'h7f, 1'b1);
    irq_chk(8'h80, 1'b0);
    for (int i = 0; i < 8; i++) begin
      p = 8'($random(seed));
      irq_chk(p, p < 8'h80);
    end
    pend_v = 1'b0;
    pulse(1, 8'h30);
    pulse(1, 8'h10);
    hacc(0, HOFF_APR_LO, 0, 32'h44);
    vacc(0, VOFF_RUNPRI, 0, 32'h10);
    pulse(0, 8'h0);
    vacc(0, VOFF_RUNPRI, 0, 32'h30);
    pulse(0, 8'h0);
    vacc(0, VOFF_RUNPRI, 0, {24'h0, IDLE_PRI_5BIT});
    vacc(1, VOFF_STATUS, 32'hf, 0);
    for (int k = 0; k < 4; k++) begin
      vacc(fw[k], fa[k], 32'h0, 32'h0);
      vacc(0, VOFF_STATUS, 0, 32'h1 << k);
      vacc(1, VOFF_STATUS, 32'h1 << k, 0);
      vacc(0, VOFF_STATUS, 0, 32'h0);
    end
    vacc(0, 12'h008, 0, 0);
    vacc(1, VOFF_IDENT, 0, 0);
    vacc(1, VOFF_STATUS, 32'h1, 0);
    vacc(0, VOFF_STATUS, 0, 32'h8);
    vacc(1, VOFF_STATUS, 32'h8, 0);
    sysreg = 1'b1;
    vacc(0, 12'h020, 0, 0);
    vacc(1, VOFF_RUNPRI, 0, 0);
    vacc(0, VOFF_STATUS, 0, 32'h0);
    sysreg = 1'b0;
    r = $random(seed) | 32'h1;
    hacc(1, HOFF_LR_HI, r, 0);
    hacc(0, HOFF_LR_HI, 0, r);
    hacc(0, HOFF_EMPTY, 0, 32'h00007fff);
    hacc(1, 12'h034, 32'hffffffff, 0);
    hacc(0, 12'h034, 0, 32'h0);
    hacc(1, HOFF_APR_HI, 32'h5, 0);
    hacc(0, HOFF_APR_HI, 0, 32'h0);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule : test_virq_cpu_if
`default_nettype wire

// >>> virq_cpu_if.sv
`timescale 1ns/1ps
`default_nettype none
module virq_cpu_if
  import virq_if_pkg::*;
#(
  parameter int         PRIO_BITS  = 5,            // Implemented priority bits
  parameter int         NUM_LR     = 16,           // Implemented list entries
  parameter bit         HAS_STATUS = 1'b1,         // Error status present
  parameter logic [3:0] ARCH_VER   = 4'h3,         // Architecture version
  parameter logic [11:0] PRODUCT   = 12'h0a5,      // Arbitrary product value
  parameter logic [3:0] REVISION   = 4'h1,         // Arbitrary revision
  parameter logic [3:0] IMPL_CONT  = 4'h1,         // Arbitrary continuation
  parameter logic [6:0] IMPL_CODE  = 7'h2a         // Arbitrary identity code
) (
  input  wire logic        clk_i,                  // Clock, 200 MHz
  input  wire logic        rstn_i,                 // Async reset, low
  input  wire bus_req_type vreq_i,                 // Virtual bank access
  output bus_rsp_type      vrsp_o,                 // Virtual bank answer
  input  wire bus_req_type hreq_i,                 // Control bank access
  output bus_rsp_type      hrsp_o,                 // Control bank answer
  input  wire logic        sysreg_en_i,            // System-register path on
  input  wire logic        pend_valid_i,           // Candidate interrupt
  input  wire logic [7:0]  pend_prio_i,            // Candidate priority
  input  wire logic        ack_i,                  // Acknowledge event
  input  wire logic [7:0]  ack_prio_i,             // Acknowledged priority
  input  wire logic        eoi_i,                  // End-of-interrupt event
  output logic             irq_o                   // Interrupt to element
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (PRIO_BITS < 5 || PRIO_BITS > 7) begin : g_bad_prio
    $error("PRIO_BITS must be 5 to 7");
  end
  if (NUM_LR < 1 || NUM_LR > NUM_LR_MAX) begin : g_bad_lr
    $error("NUM_LR must be 1 to 16");
  end
  if (ARCH_VER < ARCH_V1 || ARCH_VER > ARCH_V4) begin : g_bad_arch
    $error("ARCH_VER is a reserved code");
  end

  // ****************************************************************
  // Derived constants
  // ****************************************************************
  localparam int        SHIFT     = 8 - PRIO_BITS;         // Dropped low bits
  localparam int        APR_WORDS = 1 << (PRIO_BITS - 5);  // Implemented words
  localparam logic [7:0] MASK_KEEP = 8'(8'hff << SHIFT);    // Writable mask bits
  localparam logic [7:0] IDLE_PRI  = (PRIO_BITS == 5) ? IDLE_PRI_5BIT : IDLE_PRI_FULL;
  localparam logic [31:0] IDENT_WORD = {PRODUCT, ARCH_VER, REVISION, IMPL_CONT,
                                        1'b0, IMPL_CODE};
  localparam logic [31:0] TYPE_WORD  = 32'(PRIO_BITS - 1) << TYPE_PRI_LSB;

  // ****************************************************************
  // State
  // ****************************************************************
  state_type s_r;                                  // Registered state
  state_type s_nxt;                                // Next state

  logic        act_found;                          // Some active bit set
  logic [6:0]  act_idx;                            // Lowest set active bit
  logic [7:0]  run_pri;                            // Running priority
  logic [31:0] empty_bits;                         // Empty list status

  // ****************************************************************
  // Lowest active bit search
  // ****************************************************************
  // lowest set bit wins
  always_comb begin
    act_found = 1'b0;
    act_idx   = 7'h00;
    for (int i = (NUM_APR_MAX * 32) - 1; i >= 0; i--) begin
      // Walk downward so the lowest index is kept last
      if (s_r.apr[i / 32][i % 32]) begin
        act_found = 1'b1;
        act_idx   = 7'(i);
      end
    end
  end

  // ****************************************************************
  // Running priority
  // ****************************************************************
  always_comb begin
    if (act_found) begin
      run_pri = 8'({1'b0, act_idx} << SHIFT);
    end else begin
      run_pri = IDLE_PRI;
    end
  end

  // ****************************************************************
  // Empty list status
  // ****************************************************************
  always_comb begin
    empty_bits = 32'h0000_0000;
    for (int n = 0; n < NUM_LR; n++) begin
      empty_bits[n] = (s_r.lr[n] == 32'h0000_0000);
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [3:0]  err_set;                          // Violations this cycle
    logic [3:0]  err_clr;                          // Flags written with one
    logic [6:0]  ack_idx;                          // Bit for acknowledge
    logic [1:0]  aw;                               // Active word index
    logic [3:0]  lw;                               // List entry index
    err_set = 4'h0;
    err_clr = 4'h0;
    ack_idx = 7'h00;
    aw      = 2'h0;
    lw      = 4'h0;
    s_nxt   = s_r;

    // Answers default to a zero word
    s_nxt.vrsp.valid = vreq_i.valid & ~vreq_i.write;
    s_nxt.vrsp.rdata = 32'h0000_0000;
    s_nxt.hrsp.valid = hreq_i.valid & ~hreq_i.write;
    s_nxt.hrsp.rdata = 32'h0000_0000;

    // Priority drop on end of interrupt
    if (eoi_i && act_found) begin
      s_nxt.apr[act_idx[6:5]][act_idx[4:0]] = 1'b0;
    end
    // Active bit on acknowledge
    if (ack_i) begin
      ack_idx = 7'(ack_prio_i >> SHIFT);
      s_nxt.apr[ack_idx[6:5]][ack_idx[4:0]] = 1'b1;
    end

    // Control bank decode
    if (hreq_i.valid) begin
      if (hreq_i.addr == HOFF_CTRL) begin
        // Control word
        if (hreq_i.write) begin
          s_nxt.ctrl = hreq_i.wdata;
        end
        s_nxt.hrsp.rdata = s_r.ctrl;
      end else if (hreq_i.addr == HOFF_TYPE) begin
        // Read-only type word
        s_nxt.hrsp.rdata = TYPE_WORD;
      end else if (hreq_i.addr == HOFF_VMCR) begin
        if (hreq_i.write) begin
          s_nxt.mask      = hreq_i.wdata[VMCR_MASK_LSB +: 8] & MASK_KEEP;
          s_nxt.vmcr_rest = hreq_i.wdata[23:0];
        end
        s_nxt.hrsp.rdata = {s_r.mask, s_r.vmcr_rest};
      end else if (hreq_i.addr == HOFF_MAINT || hreq_i.addr == HOFF_EOISTAT) begin
        // Maintenance logic absent, reads zero
        s_nxt.hrsp.rdata = 32'h0000_0000;
      end else if (hreq_i.addr == HOFF_EMPTY) begin
        // Empty list bits
        s_nxt.hrsp.rdata = empty_bits;
      end else if (hreq_i.addr >= HOFF_APR_LO && hreq_i.addr <= HOFF_APR_HI) begin
        aw = hreq_i.addr[3:2];
        if (32'(aw) < APR_WORDS) begin
          if (hreq_i.write) begin
            s_nxt.apr[aw] = hreq_i.wdata;
          end
          s_nxt.hrsp.rdata = s_r.apr[aw];
        end
      end else if (hreq_i.addr >= HOFF_LR_LO && hreq_i.addr <= HOFF_LR_HI) begin
        lw = hreq_i.addr[5:2];
        if (32'(lw) < NUM_LR) begin
          if (hreq_i.write) begin
            s_nxt.lr[lw] = hreq_i.wdata;
          end
          s_nxt.hrsp.rdata = s_r.lr[lw];
        end
      end else begin
        s_nxt.hrsp.rdata = 32'h0000_0000;
      end
    end

    // Virtual bank decode
    if (vreq_i.valid) begin
      if (vreq_i.addr == VOFF_MASK) begin
        if (vreq_i.write) begin
          s_nxt.mask = vreq_i.wdata[7:0] & MASK_KEEP;
        end
        s_nxt.vrsp.rdata = {24'h00_0000, s_r.mask};
      end else if (vreq_i.addr == VOFF_RUNPRI) begin
        s_nxt.vrsp.rdata = {24'h00_0000, run_pri};
        err_set[ERR_WR_RO] = vreq_i.write;
      end else if (vreq_i.addr == VOFF_IDENT) begin
        s_nxt.vrsp.rdata = IDENT_WORD;
        err_set[ERR_WR_RO] = vreq_i.write;
      end else if (vreq_i.addr == VOFF_ACK || vreq_i.addr == VOFF_HIPEND) begin
        // Served elsewhere; reads zero here
        // write to read-only
        err_set[ERR_WR_RO] = vreq_i.write;
      end else if (vreq_i.addr == VOFF_EOI) begin
        err_set[ERR_RD_WO] = ~vreq_i.write;
      end else if (vreq_i.addr == VOFF_STATUS) begin
        if (HAS_STATUS) begin
          if (vreq_i.write) begin
            err_clr = vreq_i.wdata[3:0];
          end
          s_nxt.vrsp.rdata = {28'h000_0000, s_r.err};
        end
      end else begin
        err_set[ERR_WR_RSV] = vreq_i.write;
        err_set[ERR_RD_RSV] = ~vreq_i.write;
      end
    end

    // Violation flags; a new violation beats a clear
    if (!HAS_STATUS) begin
      s_nxt.err = 4'h0;
    end else if (sysreg_en_i) begin
      s_nxt.err = s_r.err & ~err_clr;
    end else begin
      s_nxt.err = (s_r.err & ~err_clr) | err_set;
    end

    s_nxt.irq = pend_valid_i & s_r.ctrl[CTRL_EN_BIT] & (pend_prio_i < s_r.mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign vrsp_o = s_r.vrsp;
  assign hrsp_o = s_r.hrsp;
  assign irq_o  = s_r.irq;

endmodule : virq_cpu_if
`default_nettype wire

// >>> virq_cpu_if_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module virq_cpu_if_monitor
  import virq_if_pkg::*;
#(
  parameter int PRIO_BITS = 5                 // Implemented priority bits
) (
  input wire logic        clk_i,              // Clock
  input wire logic        rstn_i,             // Reset, low
  input wire bus_req_type vreq_i,             // Virtual bank access
  input wire bus_rsp_type vrsp_o,             // Virtual bank answer
  input wire bus_req_type hreq_i,             // Control bank access
  input wire bus_rsp_type hrsp_o,             // Control bank answer
  input wire logic        sysreg_en_i,        // System path on
  input wire logic        pend_valid_i,       // Candidate present
  input wire logic [7:0]  pend_prio_i,        // Candidate priority
  input wire logic        ack_i,              // Acknowledge
  input wire logic [7:0]  ack_prio_i,         // Acknowledged priority
  input wire logic        eoi_i,              // End of interrupt
  input wire logic        irq_o               // Interrupt out
);
  // ****
  // Read decode helpers
  // ****
  logic       vrd;                            // Virtual read taken
  logic       hrd;                            // Control read taken
  logic [7:0] low_m;                          // Unimplemented mask bits
  assign vrd   = vreq_i.valid && !vreq_i.write;
  assign hrd   = hreq_i.valid && !hreq_i.write;
  assign low_m = 8'hff >> PRIO_BITS;
  // ****
  // Property checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ident_fields_a: assert property (
    vrd && vreq_i.addr == 12'h0fc |=> vrsp_o.valid && vrsp_o.rdata[7] == 1'b0)
    else $error("identification zero bit set");
  arch_code_a: assert property (
    vrd && vreq_i.addr == 12'h0fc |=> vrsp_o.rdata[19:16] inside {4'h1, 4'h2, 4'h3, 4'h4})
    else $error("version code reserved");
  mask_low_a: assert property (
    vrd && vreq_i.addr == 12'h004 |=> vrsp_o.rdata[31:8] == 24'h0
      && (vrsp_o.rdata[7:0] & low_m) == 8'h0)
    else $error("mask low bits not zero");
  runpri_low_a: assert property (
    vrd && vreq_i.addr == 12'h014 |=> vrsp_o.rdata[31:8] == 24'h0
      && ((vrsp_o.rdata[7:0] & low_m) == 8'h0 || vrsp_o.rdata[7:0] == 8'hff))
    else $error("running priority low bits set");
  irq_gate_a: assert property (
    irq_o |-> $past(pend_valid_i) && $past(pend_prio_i) != 8'hff)
    else $error("interrupt without candidate");
  rsv_read_flag_a: assert property (
    vrd && vreq_i.addr == 12'h008 && !sysreg_en_i ##2 vrd && vreq_i.addr == 12'h02c
    |=> vrsp_o.rdata[0]) else $error("reserved read not flagged");
  wo_read_flag_a: assert property (
    vrd && vreq_i.addr == 12'h010 && !sysreg_en_i ##2 vrd && vreq_i.addr == 12'h02c
    |=> vrsp_o.rdata[2]) else $error("write-only read not flagged");
  ctrl_raz_a: assert property (
    hrd && hreq_i.addr == 12'h034 |=> hrsp_o.valid && hrsp_o.rdata == 32'h0)
    else $error("reserved control word not zero");
endmodule : virq_cpu_if_monitor
bind virq_cpu_if virq_cpu_if_monitor #(.PRIO_BITS(PRIO_BITS)) mon (.clk_i, .rstn_i, .vreq_i,
  .vrsp_o, .hreq_i, .hrsp_o, .sysreg_en_i, .pend_valid_i, .pend_prio_i, .ack_i, .ack_prio_i,
  .eoi_i, .irq_o);
`default_nettype wire

// >>> virq_if_pkg.sv
// Overview of operation
// - Identification word: product, version, revision, implementer fields
// - Version codes one to four; others reserved
// - Implementer: continuation, zero bit, identity code
// - Signal only priorities numerically below mask
// - Unimplemented low mask bits read zero
// - Mask and control-view alias share storage
// - Running priority; idle reads 0xFF or 0xF8
// - Omitted status register reads zero, ignores writes
// - No violation recording under system-register access
// - Write to read-only location sets bit 3
// - Read of write-only location sets bit 2
// - Write to reserved location sets bit 1
// - Read of reserved location sets bit 0
// - Writing one clears a violation flag
// - Reserved control-bank addresses read zero, ignore writes
// - Sixteen list words at 0x100 to 0x13C
// - Active-priority words 0xF0-0xFC, reset zero
// - Empty-list bits of implemented entries reset one
// - Acknowledge sets, end-of-interrupt clears lowest bit
package virq_if_pkg;

  // ****************************************************************
  // Virtual interface bank offsets
  // ****************************************************************
  localparam logic [11:0] VOFF_MASK     = 12'h004; // Priority mask
  localparam logic [11:0] VOFF_ACK      = 12'h00c; // Acknowledge, read-only
  localparam logic [11:0] VOFF_EOI      = 12'h010; // End of interrupt, write-only
  localparam logic [11:0] VOFF_RUNPRI   = 12'h014; // Running priority
  localparam logic [11:0] VOFF_HIPEND   = 12'h018; // Highest pending, read-only
  localparam logic [11:0] VOFF_STATUS   = 12'h02c; // Access error status
  localparam logic [11:0] VOFF_IDENT    = 12'h0fc; // Identification

  // ****************************************************************
  // Control bank offsets
  // ****************************************************************
  localparam logic [11:0] HOFF_CTRL     = 12'h000; // Hypervisor control
  localparam logic [11:0] HOFF_TYPE     = 12'h004; // Interface type
  localparam logic [11:0] HOFF_VMCR     = 12'h008; // Machine control view
  localparam logic [11:0] HOFF_MAINT    = 12'h010; // Maintenance status
  localparam logic [11:0] HOFF_EOISTAT  = 12'h020; // End of interrupt status
  localparam logic [11:0] HOFF_EMPTY    = 12'h030; // Empty list status
  localparam logic [11:0] HOFF_APR_LO   = 12'h0f0; // First active-priority word
  localparam logic [11:0] HOFF_APR_HI   = 12'h0fc; // Last active-priority word
  localparam logic [11:0] HOFF_LR_LO    = 12'h100; // First list entry
  localparam logic [11:0] HOFF_LR_HI    = 12'h13c; // Last list entry

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int          ID_PROD_LSB   = 20;      // Product [31:20]
  localparam int          ID_ARCH_LSB   = 16;      // Version [19:16]
  localparam int          ID_REV_LSB    = 12;      // Revision [15:12]
  localparam int          ID_CONT_LSB   = 8;       // Continuation [11:8]
  localparam int          VMCR_MASK_LSB = 24;      // Alias field [31:24]
  localparam int          TYPE_PRI_LSB  = 29;      // Priority bits [31:29]
  localparam int          ERR_WR_RO     = 3;       // write_readonly_flag
  localparam int          ERR_RD_WO     = 2;       // read_writeonly_flag
  localparam int          ERR_WR_RSV    = 1;       // write_reserved_flag
  localparam int          ERR_RD_RSV    = 0;       // read_reserved_flag
  localparam int          CTRL_EN_BIT   = 0;       // Signalling enable
  localparam logic [3:0]  ARCH_V1       = 4'h1;    // Version one
  localparam logic [3:0]  ARCH_V4       = 4'h4;    // Version four, mapped
  localparam logic [7:0]  IDLE_PRI_FULL = 8'hff;   // Idle running priority
  localparam logic [7:0]  IDLE_PRI_5BIT = 8'hf8;   // Idle with five bits
  localparam int          NUM_LR_MAX    = 16;      // List entries storage
  localparam int          NUM_APR_MAX   = 4;       // Active words storage

  // ****************************************************************
  // Carrier and state types
  // ****************************************************************
  typedef struct packed {
    logic        valid;                            // Access this cycle
    logic        write;                            // 1 write, 0 read
    logic [11:0] addr;                             // Byte offset
    logic [31:0] wdata;                            // Write data
  } bus_req_type;

  typedef struct packed {
    logic        valid;                            // Read data valid
    logic [31:0] rdata;                            // Read data
  } bus_rsp_type;

  typedef struct packed {
    logic [7:0]                     mask;          // Shared priority mask
    logic [23:0]                    vmcr_rest;     // Other view bits
    logic [31:0]                    ctrl;          // Hypervisor control
    logic [3:0]                     err;           // Violation flags
    logic [NUM_APR_MAX-1:0][31:0]   apr;           // Active priorities
    logic [NUM_LR_MAX-1:0][31:0]    lr;            // List entries
    bus_rsp_type                    vrsp;          // Virtual bank answer
    bus_rsp_type                    hrsp;          // Control bank answer
    logic                           irq;           // Signal to element
  } state_type;

  localparam state_type STATE_RST = '0;            // All zero after reset

endpackage : virq_if_pkg
